// ===== hw/tvpll_core.sv
// Function
// - 14-bit dual-modulus divider, 32/33 plus 5/9-bit counters
// - 5-bit counter selects divide by 33
// - Ratios 1024 to 16383 supported and programmed
// - 18-bit shift register and 18-bit latch
// - Shift data on clock fall while enable high
// - Count telegram bits, check exactly eighteen
// - Latch loads on enable fall after eighteen bits; outputs use latch
// - Crystal divided by 2048 for reference
// - VCO fall first gives DOWN for phase gap
// - Reference fall first gives UP for gap
// - UP sources, DOWN sinks, both low is high-Z
// - Lock output is NOR of UP and DOWN
// - Pump bit selects base or tenfold current
// - Band outputs decoded from latched bits 15-17
`timescale 1ns/100ps
module tvpll_core (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic vco_in,
   input  wire logic xtal_in,
   input  wire logic shift_clock_in,
   input  wire logic serial_data_in,
   input  wire logic latch_load_enable,
   output logic      band_out_1,
   output logic      band_out_2,
   output logic      band_out_3,
   output logic      band_out_4,
   output logic      band_out_5,
   output logic      pump_up,
   output logic      pump_down,
   output logic      charge_pump_out,
   output logic      charge_pump_oe_n,
   output logic      pump_current_high,
   output logic      lock_out,
   output logic      telegram_error
);
   import tvpll_pkg::*;

   typedef struct packed {
      logic [SYNC_W-1:0] prev;
      logic [TEL_W-1:0]  shreg;
      logic [4:0]        bit_cnt;
      tvpll_rx_t         rx;
      logic [TEL_W-1:0]  latch;
      logic [REF_W-1:0]  ref_cnt;
      logic              ref_fall;
      logic              up;
      logic              down;
      logic [BAND_W-1:0] band;
      logic              pump_hi;
      logic              word_err;
   } tvpll_core_state_t;

   tvpll_core_state_t st_ff;
   tvpll_core_state_t nxt_st;
   logic [SYNC_W-1:0] pin_s;
   logic              xtal_tick;
   logic              sclk_fall;
   logic              le_rise;
   logic              le_fall;
   logic              b15;
   logic              b16;
   logic              b17;

   tvpll_div_if dif ();

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   // All pins are asynchronous to sys_clk
   tvpll_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .async_in ({latch_load_enable, serial_data_in, shift_clock_in, xtal_in, vco_in}),
      .sync_out (pin_s)
   );

   tvpll_divider u_div (
      .sys_clk (sys_clk),
      .reset   (reset),
      .dif     (dif)
   );

   assign dif.vco_tick = pin_s[SI_VCO] & ~st_ff.prev[SI_VCO];
   assign dif.ratio    = ~st_ff.latch[RATIO_W-1:0];
   assign xtal_tick    = pin_s[SI_XTAL] & ~st_ff.prev[SI_XTAL];
   assign sclk_fall    = ~pin_s[SI_SCLK] & st_ff.prev[SI_SCLK];
   assign le_rise      = pin_s[SI_LE] & ~st_ff.prev[SI_LE];
   assign le_fall      = ~pin_s[SI_LE] & st_ff.prev[SI_LE];
   assign b15          = st_ff.latch[BAND_B15];
   assign b16          = st_ff.latch[BAND_B16];
   assign b17          = st_ff.latch[BAND_B17];

   always_comb begin
      nxt_st          = st_ff;
      nxt_st.prev     = pin_s;
      nxt_st.ref_fall = 1'b0;

      // Telegram receiver
      case (st_ff.rx)
         RX_IDLE, RX_DONE: begin
            nxt_st.rx = RX_IDLE;
            if (le_rise) begin
               nxt_st.rx      = RX_SHIFT;
               nxt_st.bit_cnt = '0;
            end
         end
         RX_SHIFT: begin
            if (le_fall) begin
               nxt_st.rx = RX_DONE;
               if (st_ff.bit_cnt == TEL_LEN) begin
                  nxt_st.latch    = st_ff.shreg;
                  nxt_st.word_err = 1'b0;
               end else begin
                  nxt_st.word_err = 1'b1;
               end
            end else if (sclk_fall && pin_s[SI_LE]) begin
               // First bit sent ends in bit 0 after eighteen shifts
               nxt_st.shreg = {pin_s[SI_SDAT], st_ff.shreg[TEL_W-1:1]};
               if (st_ff.bit_cnt != CNT_MAX) begin
                  nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
               end
            end
         end
         default: begin
            nxt_st.rx = RX_IDLE;
         end
      endcase

      // Reference divider
      if (xtal_tick) begin
         nxt_st.ref_cnt  = st_ff.ref_cnt + 11'h001;
         nxt_st.ref_fall = st_ff.ref_cnt == REF_LAST;
      end

      // Phase-frequency detector on falling edges
      if (dif.div_fall && st_ff.ref_fall) begin
         nxt_st.up   = 1'b0;
         nxt_st.down = 1'b0;
      end else if (dif.div_fall) begin
         if (st_ff.up) begin
            nxt_st.up = 1'b0;
         end else begin
            nxt_st.down = 1'b1;
         end
      end else if (st_ff.ref_fall) begin
         if (st_ff.down) begin
            nxt_st.down = 1'b0;
         end else begin
            nxt_st.up = 1'b1;
         end
      end

      // Band decode, low means conducting
      nxt_st.band    = {~(b16 & ~b17), b16 | b17, b17, b16, b15};
      nxt_st.pump_hi = st_ff.latch[PUMP_BIT];
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_ff          <= '0;
         st_ff.rx       <= RX_IDLE;
         st_ff.latch    <= LATCH_RST;
         st_ff.band     <= 5'h10;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign band_out_1        = st_ff.band[0];
   assign band_out_2        = st_ff.band[1];
   assign band_out_3        = st_ff.band[2];
   assign band_out_4        = st_ff.band[3];
   assign band_out_5        = st_ff.band[4];
   assign pump_up           = st_ff.up;
   assign pump_down         = st_ff.down;
   assign charge_pump_out   = st_ff.up;
   assign charge_pump_oe_n  = ~(st_ff.up | st_ff.down);
   assign lock_out          = ~(st_ff.up | st_ff.down);
   assign pump_current_high = st_ff.pump_hi;
   assign telegram_error    = st_ff.word_err;

   // Helper: crystal ticks between reference falls
   logic [REF_W:0] hlp_xt;
   logic           hlp_xt_seen;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hlp_xt      <= '0;
         hlp_xt_seen <= 1'b0;
      end else if (st_ff.ref_fall) begin
         hlp_xt      <= '0;
         hlp_xt_seen <= 1'b1;
      end else if (xtal_tick) begin
         hlp_xt <= hlp_xt + 12'h001;
      end
   end

   chk_ref_period: assert property (st_ff.ref_fall && hlp_xt_seen |-> hlp_xt == 12'(REF_DIV))
      else $error("reference period is not 2048 crystal cycles");
   chk_down_on_vco: assert property (dif.div_fall && !st_ff.ref_fall && !st_ff.up |=> pump_down && !pump_up)
      else $error("early divided edge did not raise DOWN");
   chk_up_on_ref: assert property (st_ff.ref_fall && !dif.div_fall && !st_ff.down |=> pump_up && !pump_down)
      else $error("early reference edge did not raise UP");
   chk_up_holds: assert property ($rose(pump_up) |-> pump_up until_with dif.div_fall)
      else $error("UP dropped before divided edge");
   chk_lock_nor: assert property ($fell(lock_out) |-> $rose(pump_up) || $rose(pump_down))
      else $error("lock fell without a correction pulse");
   chk_pump_hiz: assert property (!pump_up && !pump_down |-> charge_pump_oe_n && lock_out)
      else $error("pump driven with both pulses low");
   chk_shift_count: assert property (st_ff.rx == RX_SHIFT && sclk_fall && pin_s[SI_LE] && st_ff.bit_cnt < CNT_MAX
      |=> st_ff.bit_cnt == $past(st_ff.bit_cnt) + 5'h01)
      else $error("shift edge not counted");
   chk_latch_good: assert property (st_ff.rx == RX_SHIFT && le_fall && st_ff.bit_cnt == TEL_LEN
      |=> st_ff.latch == $past(st_ff.shreg) && !telegram_error)
      else $error("full telegram not latched");
   chk_latch_keep: assert property (st_ff.rx == RX_SHIFT && le_fall && st_ff.bit_cnt != TEL_LEN
      |=> $stable(st_ff.latch) && telegram_error)
      else $error("short telegram altered latch");
   chk_band_map: assert property ($changed(st_ff.latch) |=> ##1 band_out_4 == ($past(b16, 2) | $past(b17, 2))
      && band_out_5 == !($past(b16, 2) && !$past(b17, 2)))
      else $error("band outputs do not follow latch");
   chk_pump_select: assert property ($changed(st_ff.latch[PUMP_BIT]) |=> pump_current_high == $past(st_ff.latch[PUMP_BIT]))
      else $error("pump select does not follow latch");

   cov_good_telegram: cover property (st_ff.rx == RX_SHIFT && le_fall && st_ff.bit_cnt == TEL_LEN);
   cov_bad_telegram: cover property (st_ff.rx == RX_SHIFT && le_fall && st_ff.bit_cnt != TEL_LEN);
   cov_up_pulse: cover property ($rose(pump_up) ##[1:1000] $fell(pump_up));
   cov_down_pulse: cover property ($rose(pump_down) ##[1:1000] $fell(pump_down));
endmodule

// ===== hw/tvpll_pkg.sv
package tvpll_pkg;
   // Telegram layout
   localparam int TEL_W    = 18;
   localparam int RATIO_W  = 14;
   localparam int PUMP_BIT = 14;
   localparam int BAND_B15 = 15;
   localparam int BAND_B16 = 16;
   localparam int BAND_B17 = 17;
   localparam int BAND_W   = 5;
   localparam logic [4:0]        TEL_LEN   = 5'h12;
   localparam logic [4:0]        CNT_MAX   = 5'h1F;
   localparam logic [TEL_W-1:0]  LATCH_RST = 18'h00000;

   // Dual-modulus divider
   localparam int SWAL_W  = 5;
   localparam int MAIN_W  = 9;
   localparam int PRESC_W = 6;
   localparam logic [PRESC_W-1:0] PRESC_LAST_32 = 6'h1F;
   localparam logic [PRESC_W-1:0] PRESC_LAST_33 = 6'h20;
   localparam logic [RATIO_W-1:0] RATIO_MIN     = 14'h0400;
   localparam logic [RATIO_W-1:0] RATIO_MAX     = 14'h3FFF;
   localparam logic [RATIO_W-1:0] RATIO_RST     = ~LATCH_RST[RATIO_W-1:0];

   // Reference divider
   localparam int REF_DIV = 2048;
   localparam int REF_W   = 11;
   localparam logic [REF_W-1:0] REF_LAST = 11'(REF_DIV - 1);

   // Synchroniser lanes
   localparam int SYNC_W  = 5;
   localparam int SI_VCO  = 0;
   localparam int SI_XTAL = 1;
   localparam int SI_SCLK = 2;
   localparam int SI_SDAT = 3;
   localparam int SI_LE   = 4;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'h0,
      RX_SHIFT = 2'h1,
      RX_DONE  = 2'h3
   } tvpll_rx_t;
endpackage

// ===== hw/tvpll_div_if.sv
`timescale 1ns/100ps
interface tvpll_div_if;
   import tvpll_pkg::*;
   logic [RATIO_W-1:0] ratio;
   logic               vco_tick;
   logic               div_fall;

   modport ctl (output ratio, output vco_tick, input div_fall);
   modport div (input ratio, input vco_tick, output div_fall);
endinterface

// ===== hw/tvpll_sync.sv
`timescale 1ns/100ps
module tvpll_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } tvpll_sync_state_t;

   tvpll_sync_state_t st_ff;
   tvpll_sync_state_t nxt_st;

   always_comb begin
      nxt_st.meta = async_in;
      nxt_st.sync = st_ff.meta;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.sync;
endmodule

// ===== hw/tvpll_divider.sv
`timescale 1ns/100ps
module tvpll_divider (
   input  wire logic sys_clk,
   input  wire logic reset,
   tvpll_div_if.div  dif
);
   import tvpll_pkg::*;

   typedef struct packed {
      logic [PRESC_W-1:0] presc;
      logic [SWAL_W-1:0]  swal;
      logic [MAIN_W-1:0]  main;
      logic               mod33;
      logic [RATIO_W-1:0] ratio;
      logic               fall;
   } tvpll_div_state_t;

   tvpll_div_state_t st_ff;
   tvpll_div_state_t nxt_st;
   logic             presc_end;
   logic             cycle_end;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   always_comb begin
      nxt_st    = st_ff;
      nxt_st.fall = 1'b0;
      presc_end = st_ff.presc == (st_ff.mod33 ? PRESC_LAST_33 : PRESC_LAST_32);
      cycle_end = st_ff.main == st_ff.ratio[RATIO_W-1:SWAL_W] - 9'h001;
      if (dif.vco_tick) begin
         nxt_st.presc = st_ff.presc + 6'h01;
         if (presc_end) begin
            nxt_st.presc = '0;
            if (cycle_end) begin
               // New ratio only at the cycle boundary
               nxt_st.ratio = dif.ratio;
               nxt_st.swal  = dif.ratio[SWAL_W-1:0];
               nxt_st.mod33 = |dif.ratio[SWAL_W-1:0];
               nxt_st.main  = '0;
               nxt_st.fall  = 1'b1;
            end else begin
               nxt_st.main = st_ff.main + 9'h001;
               if (st_ff.swal != '0) begin
                  nxt_st.swal = st_ff.swal - 5'h01;
               end
               nxt_st.mod33 = nxt_st.swal != '0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_ff.presc <= '0;
         st_ff.swal  <= RATIO_RST[SWAL_W-1:0];
         st_ff.main  <= '0;
         st_ff.mod33 <= |RATIO_RST[SWAL_W-1:0];
         st_ff.ratio <= RATIO_RST;
         st_ff.fall  <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dif.div_fall = st_ff.fall;

   // Helper: input ticks per division cycle
   logic [RATIO_W-1:0] hlp_ticks;
   logic [RATIO_W-1:0] hlp_ratio;
   logic               hlp_seen;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hlp_ticks <= '0;
         hlp_ratio <= '0;
         hlp_seen  <= 1'b0;
      end else if (st_ff.fall) begin
         hlp_ticks <= '0;
         hlp_ratio <= st_ff.ratio;
         hlp_seen  <= 1'b1;
      end else if (dif.vco_tick) begin
         hlp_ticks <= hlp_ticks + 14'h0001;
      end
   end

   chk_cycle_length: assert property (st_ff.fall && hlp_seen && hlp_ratio >= RATIO_MIN |-> hlp_ticks == hlp_ratio)
      else $error("division cycle length differs from ratio");
   chk_modulus_select: assert property (st_ff.mod33 == (st_ff.swal != '0))
      else $error("modulus select disagrees with swallow count");
   chk_presc_bound: assert property (st_ff.presc <= PRESC_LAST_33)
      else $error("prescaler count out of range");
endmodule

// ===== testbench/tvpll_uc_model.sv
`timescale 1ns/100ps
module tvpll_uc_model (
   input  wire logic sys_clk,
   output logic      shift_clock_in,
   output logic      serial_data_in,
   output logic      latch_load_enable
);
   initial begin
      shift_clock_in    = 1'b0;
      serial_data_in    = 1'b1;
      latch_load_enable = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // Word bit 0 goes out first; data holds 4 cycles either side of each fall
   task automatic send(input logic [31:0] word, input int nbits);
      tick(1);
      latch_load_enable = 1'b1;
      tick(4);
      for (int i = 0; i < nbits; i++) begin
         serial_data_in = word[i];
         shift_clock_in = 1'b1;
         tick(4);
         shift_clock_in = 1'b0;
         tick(4);
      end
      serial_data_in    = ~serial_data_in;
      latch_load_enable = 1'b0;
      tick(8);
   endtask
endmodule

// ===== testbench/tb.sv
`timescale 1ns/100ps
module tb;
   import tvpll_pkg::*;
   localparam logic [13:0] N_DIV = 14'h041A;
   logic       sys_clk;
   logic       reset;
   logic       vco_in;
   logic       xtal_in;
   logic       shift_clock_in;
   logic       serial_data_in;
   logic       latch_load_enable;
   logic [4:0] bands;
   logic       band_out_1, band_out_2, band_out_3, band_out_4, band_out_5;
   logic       pump_up, pump_down, charge_pump_out, charge_pump_oe_n;
   logic       pump_current_high, lock_out, telegram_error;
   int         mismatches;
   int         n_checks;
   int         vco_half;
   int         cnt;
   int         oth;

   assign bands = {band_out_5, band_out_4, band_out_3, band_out_2, band_out_1};

   tvpll_uc_model uc (.sys_clk(sys_clk), .shift_clock_in(shift_clock_in), .serial_data_in(serial_data_in),
                      .latch_load_enable(latch_load_enable));

   tvpll_core dut (.sys_clk(sys_clk), .reset(reset), .vco_in(vco_in), .xtal_in(xtal_in),
                   .shift_clock_in(shift_clock_in), .serial_data_in(serial_data_in),
                   .latch_load_enable(latch_load_enable), .band_out_1(band_out_1), .band_out_2(band_out_2),
                   .band_out_3(band_out_3), .band_out_4(band_out_4), .band_out_5(band_out_5),
                   .pump_up(pump_up), .pump_down(pump_down), .charge_pump_out(charge_pump_out),
                   .charge_pump_oe_n(charge_pump_oe_n), .pump_current_high(pump_current_high),
                   .lock_out(lock_out), .telegram_error(telegram_error));

   initial sys_clk = 1'b0;
   always #20 sys_clk = ~sys_clk;

   // Prescaled VCO and crystal pins, both stepped just after a rising edge
   always begin
      repeat (vco_half) @(posedge sys_clk);
      #1 vco_in = ~vco_in;
   end
   always begin
      repeat (2) @(posedge sys_clk);
      #1 xtal_in = ~xtal_in;
   end

   task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s: got %0h exp %0h", $time, what, got, exp);
      end
   endtask

   task automatic chk_count(input int got, input int exp, input string what);
      n_checks++;
      if (got != exp) begin
         mismatches++;
         $display("[ERR] %0t %s: got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   // Returns {b5,b4,b3,b2,b1} for code {b17,b16,b15}
   function automatic logic [4:0] band_exp(input logic [2:0] c);
      return {~(c[1] & ~c[2]), c[1] | c[2], c[2], c[1], c[0]};
   endfunction

   // Counts cycles up to the next fall of UP or DOWN, and cycles the other one is high
   task automatic wait_fall(input bit down, input int lim, output int n, output int other);
      logic prev;
      logic cur;
      n     = 0;
      other = 0;
      prev  = down ? pump_down : pump_up;
      while (n < lim) begin
         @(negedge sys_clk);
         cur = down ? pump_down : pump_up;
         if ((down ? pump_up : pump_down) === 1'b1) other++;
         n++;
         if (prev === 1'b1 && cur === 1'b0) break;
         prev = cur;
      end
   endtask

   always @(negedge sys_clk) begin
      if (reset === 1'b0) begin
         chk_bits(8'({lock_out, charge_pump_oe_n, pump_up & pump_down}),
                  8'({~(pump_up | pump_down), ~(pump_up | pump_down), 1'b0}), "lock or enable");
         if (pump_up === 1'b1 || pump_down === 1'b1) chk_bits(8'(charge_pump_out), 8'(pump_up), "pump sense");
      end
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (95000) @(posedge sys_clk);
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      end_of_test();
   end

   initial begin
      reset      = 1'b1;
      vco_in     = 1'b0;
      xtal_in    = 1'b0;
      vco_half   = 2;
      mismatches = 0;
      n_checks   = 0;
      repeat (4) @(posedge sys_clk);
      #1 reset = 1'b0;
      @(negedge sys_clk);
      chk_bits(8'(bands), 8'h10, "reset bands");
      chk_bits(8'({pump_current_high, telegram_error}), 8'h00, "reset flags");
      $display("test reset done");
      repeat (3) @(posedge sys_clk);
      for (int c = 0; c < 8; c++) begin
         uc.send({14'h0000, 3'(c), c[0] ^ c[2], ~N_DIV}, 18);
         chk_bits(8'(bands), 8'(band_exp(3'(c))), "band decode");
         chk_bits(8'({pump_current_high, telegram_error}), 8'({c[0] ^ c[2], 1'b0}), "pump select");
      end
      $display("test band table done");
      for (int n = 17; n <= 19; n += 2) begin
         uc.send({14'h0000, 3'h0, 1'b1, ~N_DIV}, n);
         chk_bits(8'(bands), 8'h1F, "bands kept");
         chk_bits(8'({pump_current_high, telegram_error}), 8'h01, "length error");
      end
      uc.send({14'h0000, 3'h2, 1'b1, ~N_DIV}, 18);
      chk_bits(8'({bands, pump_current_high, telegram_error}), 8'({band_exp(3'h2), 2'h2}), "reload");
      $display("test telegram length done");
      // Reset ratio ends one tick before the eighth reference edge, so the
      // next two divided edges trail the reference (UP), then DOWN takes over
      wait_fall(1'b0, 70000, cnt, oth);
      wait_fall(1'b0, 20000, cnt, oth);
      chk_count(cnt, 4 * int'(N_DIV), "divided period");
      chk_count(oth, 0, "down while reference leads");
      $display("test reference leads done");
      wait_fall(1'b1, 20000, cnt, oth);
      wait_fall(1'b1, 20000, cnt, oth);
      chk_count(cnt, 2048 * 4, "reference period");
      chk_count(oth, 0, "up while vco leads");
      $display("test vco leads done");
      end_of_test();
   end
endmodule
